//--- verilog/psc_pkg.sv
package psc_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam longint unsigned CLK_HZ           = 125_000_000;
	localparam int              CNT_W            = 34;
	localparam longint unsigned T_SERIAL_READY_MS = 300;
	localparam longint unsigned T_START_MS       = 300;
	localparam longint unsigned T_START_COOLED_S = 90;
	localparam longint unsigned T_HIGH_ENTRY_MS  = 300;
	localparam longint unsigned T_POWER_DOWN_MS  = 300;
	localparam longint unsigned T_FAULT_RESET_US = 10;

	// Longest times round down, least times round up
	localparam logic [CNT_W-1:0] SERIAL_READY_CYC_DEF =
		CNT_W'(T_SERIAL_READY_MS * CLK_HZ / 1000);
	localparam logic [CNT_W-1:0] START_CYC_DEF =
		CNT_W'(T_START_MS * CLK_HZ / 1000);
	localparam logic [CNT_W-1:0] START_COOLED_CYC_DEF =
		CNT_W'(T_START_COOLED_S * CLK_HZ);
	localparam logic [CNT_W-1:0] HIGH_ENTRY_CYC_DEF =
		CNT_W'(T_HIGH_ENTRY_MS * CLK_HZ / 1000);
	localparam logic [CNT_W-1:0] POWER_DOWN_CYC_DEF =
		CNT_W'(T_POWER_DOWN_MS * CLK_HZ / 1000);
	localparam logic [CNT_W-1:0] FAULT_RESET_CYC =
		CNT_W'((T_FAULT_RESET_US * CLK_HZ + 999_999) / 1_000_000);

	// ------------------------------------------------------------
	// Memory map of the serial read port
	// ------------------------------------------------------------
	localparam int         MEM_AW       = 4;
	localparam logic [3:0] OFS_TEMP     = 4'h8;
	localparam logic [3:0] OFS_VCC      = 4'h9;
	localparam logic [3:0] OFS_BIAS     = 4'ha;
	localparam logic [3:0] OFS_TX_PWR   = 4'hb;
	localparam logic [3:0] OFS_RX_PWR   = 4'hc;
	localparam logic [3:0] OFS_STATUS   = 4'hd;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		PSC_ST_START = 5'h01,
		PSC_ST_LOW   = 5'h02,
		PSC_ST_UP    = 5'h04,
		PSC_ST_HIGH  = 5'h08,
		PSC_ST_DOWN  = 5'h10
	} psc_pwr_st_t;

	typedef struct packed {
		logic [7:0] temp;
		logic [7:0] vcc;
		logic [7:0] bias;
		logic [7:0] tx_pwr;
		logic [7:0] rx_pwr;
	} psc_diag_t;

	typedef struct packed {
		logic stop;
		logic high;
	} psc_pwr_cmd_t;

	typedef struct packed {
		logic              rd;
		logic [MEM_AW-1:0] addr;
	} psc_mem_req_t;

	typedef struct packed {
		logic       ack;
		logic       ok;
		logic [7:0] data;
	} psc_mem_rsp_t;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             done;
	} psc_tmr_state_t;

	typedef struct packed {
		psc_pwr_st_t  st;
		logic         cap;
		logic         cooled;
		logic         off_prev;
		logic         laser_en;
		logic         fault_oe;
		logic         los_oe;
		logic         los_seen;
		logic         rx_rate;
		logic         abs_oe;
		logic         oper;
		logic         high_pwr;
		psc_mem_rsp_t mem;
	} psc_top_state_t;

endpackage : psc_pkg

//--- verilog/psc_timer.sv
module psc_timer (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     sys_rst_i,
	// Control
	input  wire logic                     start_i,
	input  wire logic                     run_i,
	input  wire logic [psc_pkg::CNT_W-1:0] limit_i,
	// Status
	output logic                          done_o
);
	import psc_pkg::*;

	psc_tmr_state_t s_q;
	psc_tmr_state_t s_d;

	// Saturates at the limit so done holds until restart or stop
	always_comb
	begin
		s_d = s_q;
		if (!run_i || start_i)
		begin
			s_d.cnt = '0;
		end
		else if (s_q.cnt != limit_i)
		begin
			s_d.cnt = s_q.cnt + CNT_W'(1);
		end
		s_d.done = run_i && !start_i && (s_d.cnt == limit_i);
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign done_o = s_q.done;

endmodule : psc_timer

//--- verilog/psc_top.sv
// Summary of operation
// - Laser off while off-request high or open
// - Fault flag released high on laser fault
// - Signal-lost released high on low light
// - Signal-lost line also sampled as input
// - Module-absent line held at ground
// - Rate picks pulled low; receive one used
// - Laser off within 100 us of request
// - Laser back within 2 ms of release
// - Serial interface ready within 300 ms
// - Uncooled part operational within 300 ms
// - Cooled part operational within 90 s
// - Uncooled high power within 300 ms
// - Back to low power within 300 ms
// - Host reads identity and diagnostics serially
// - Off-request held 10 us clears fault
// - Cooled fault flagged within 50 ms
// - Signal-lost follows light within 100 us
module psc_top #(
	parameter logic [psc_pkg::CNT_W-1:0] SERIAL_READY_CYC =
		psc_pkg::SERIAL_READY_CYC_DEF,
	parameter logic [psc_pkg::CNT_W-1:0] START_CYC = psc_pkg::START_CYC_DEF,
	parameter logic [psc_pkg::CNT_W-1:0] START_COOLED_CYC =
		psc_pkg::START_COOLED_CYC_DEF,
	parameter logic [psc_pkg::CNT_W-1:0] HIGH_ENTRY_CYC =
		psc_pkg::HIGH_ENTRY_CYC_DEF,
	parameter logic [psc_pkg::CNT_W-1:0] POWER_DOWN_CYC =
		psc_pkg::POWER_DOWN_CYC_DEF,
	// Arbitrary identity bytes
	parameter logic [63:0]               ID_BYTES = 64'h0011_2233_4455_6677
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  sys_rst_i,
	// Transmitter
	input  wire logic                  laser_off_req_i,
	input  wire logic                  laser_fault_i,
	input  wire logic                  cooled_i,
	output logic                       laser_en_o,
	output logic                       tx_fault_o,
	output logic                       tx_fault_oe_o,
	// Receiver
	input  wire logic                  light_low_i,
	input  wire logic                  los_line_i,
	output logic                       los_o,
	output logic                       los_oe_o,
	output logic                       los_line_seen_o,
	// Presence and rate
	output logic                       module_absent_flag_o,
	output logic                       module_absent_flag_oe_o,
	input  wire logic                  receive_rate_pick_i,
	input  wire logic                  transmit_rate_pick_i,
	output logic                       rx_rate_sel_o,
	// Power level and status
	input  wire psc_pkg::psc_pwr_cmd_t pwr_cmd_i,
	output logic                       serial_if_ready_o,
	output logic                       operational_o,
	output logic                       high_power_o,
	// Serial memory port
	input  wire psc_pkg::psc_mem_req_t mem_req_i,
	input  wire psc_pkg::psc_diag_t    diag_i,
	output psc_pkg::psc_mem_rsp_t      mem_rsp_o
);
	import psc_pkg::*;

	psc_top_state_t   s_q;
	psc_top_state_t   s_d;
	logic             hold_done;
	logic             main_done;
	logic             main_start;
	logic             main_run;
	logic [CNT_W-1:0] main_limit;
	logic             fault_now;
	logic             cooled_eff;
	logic             cmd_up;
	logic             cmd_down;
	logic [7:0]       rd_byte;
	logic             unused_pick;

	// The pin level is deliberately never read
	assign unused_pick = transmit_rate_pick_i;

	// ------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------
	psc_timer u_serial_tmr (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (1'b0),
		.run_i     (1'b1),
		.limit_i   (SERIAL_READY_CYC),
		.done_o    (serial_if_ready_o)
	);

	// Hold counter restarts whenever the request drops
	psc_timer u_hold_tmr (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (1'b0),
		.run_i     (laser_off_req_i),
		.limit_i   (FAULT_RESET_CYC),
		.done_o    (hold_done)
	);

	psc_timer u_main_tmr (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (main_start),
		.run_i     (main_run),
		.limit_i   (main_limit),
		.done_o    (main_done)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		cooled_eff = s_q.cap ? s_q.cooled : cooled_i;
		main_run   = (s_q.st == PSC_ST_START) || (s_q.st == PSC_ST_UP) ||
			(s_q.st == PSC_ST_DOWN);
		case (s_q.st)
			PSC_ST_START: main_limit = cooled_eff ? START_COOLED_CYC :
				START_CYC;
			PSC_ST_UP:    main_limit = cooled_eff ? START_COOLED_CYC :
				HIGH_ENTRY_CYC;
			PSC_ST_DOWN:  main_limit = POWER_DOWN_CYC;
			default:      main_limit = '0;
		endcase
	end

	always_comb
	begin
		s_d          = s_q;
		main_start   = 1'b0;
		cmd_up       = pwr_cmd_i.stop && pwr_cmd_i.high;
		cmd_down     = pwr_cmd_i.stop && !pwr_cmd_i.high;
		s_d.cap      = 1'b1;
		s_d.cooled   = cooled_eff;
		s_d.off_prev = laser_off_req_i;

		// New fault wins over a completed clearing hold
		fault_now = laser_fault_i || (!s_q.fault_oe && !hold_done);
		s_d.fault_oe = !fault_now;

		case (s_q.st)
			PSC_ST_START:
			begin
				if (s_q.off_prev && !laser_off_req_i)
				begin
					main_start = 1'b1;
				end
				else if (main_done)
				begin
					s_d.st = PSC_ST_LOW;
				end
			end
			PSC_ST_LOW:
			begin
				if (cmd_up)
				begin
					s_d.st = PSC_ST_UP;
				end
			end
			PSC_ST_UP:
			begin
				if (cmd_down)
				begin
					s_d.st = PSC_ST_DOWN;
				end
				else if (main_done)
				begin
					s_d.st = PSC_ST_HIGH;
				end
			end
			PSC_ST_HIGH:
			begin
				if (cmd_down)
				begin
					s_d.st = PSC_ST_DOWN;
				end
			end
			PSC_ST_DOWN:
			begin
				if (cmd_up)
				begin
					s_d.st = PSC_ST_UP;
				end
				else if (main_done)
				begin
					s_d.st = PSC_ST_LOW;
				end
			end
			default:
			begin
				s_d.st = PSC_ST_START;
			end
		endcase

		// Fault recovery reruns initialisation
		if (!s_q.fault_oe && !fault_now)
		begin
			s_d.st     = PSC_ST_START;
			main_start = 1'b1;
		end
		if (s_d.st != s_q.st)
		begin
			main_start = 1'b1;
		end

		// Single-cycle response keeps far inside both time limits
		s_d.laser_en = !laser_off_req_i && !fault_now;
		s_d.los_oe   = !light_low_i;
		s_d.los_seen = los_line_i;
		s_d.rx_rate  = receive_rate_pick_i;
		s_d.abs_oe   = 1'b1;
		s_d.oper     = !fault_now && ((s_d.st == PSC_ST_LOW) ||
			(s_d.st == PSC_ST_HIGH));
		s_d.high_pwr = (s_d.st == PSC_ST_UP) || (s_d.st == PSC_ST_HIGH) ||
			(s_d.st == PSC_ST_DOWN);

		// Serial memory read, refused before the interface is ready
		case (mem_req_i.addr)
			OFS_TEMP:   rd_byte = diag_i.temp;
			OFS_VCC:    rd_byte = diag_i.vcc;
			OFS_BIAS:   rd_byte = diag_i.bias;
			OFS_TX_PWR: rd_byte = diag_i.tx_pwr;
			OFS_RX_PWR: rd_byte = diag_i.rx_pwr;
			OFS_STATUS: rd_byte = {4'h0, s_q.oper, s_q.laser_en,
				!s_q.los_oe, !s_q.fault_oe};
			default:    rd_byte = mem_req_i.addr[3] ? 8'h00 :
				ID_BYTES[8*mem_req_i.addr[2:0] +: 8];
		endcase
		s_d.mem.ack  = mem_req_i.rd;
		s_d.mem.ok   = mem_req_i.rd && serial_if_ready_o;
		s_d.mem.data = s_d.mem.ok ? rd_byte : 8'h00;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			s_q          <= '0;
			s_q.st       <= PSC_ST_START;
			s_q.off_prev <= 1'b1;
			s_q.fault_oe <= 1'b1;
			s_q.los_oe   <= 1'b1;
			s_q.abs_oe   <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign laser_en_o              = s_q.laser_en;
	assign tx_fault_o              = 1'b0;
	assign tx_fault_oe_o           = s_q.fault_oe;
	assign los_o                   = 1'b0;
	assign los_oe_o                = s_q.los_oe;
	assign los_line_seen_o         = s_q.los_seen;
	assign module_absent_flag_o    = 1'b0;
	assign module_absent_flag_oe_o = s_q.abs_oe;
	assign rx_rate_sel_o           = s_q.rx_rate;
	assign operational_o           = s_q.oper;
	assign high_power_o            = s_q.high_pwr;
	assign mem_rsp_o               = s_q.mem;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [CNT_W-1:0] since_rst_q;
	logic [CNT_W-1:0] dwell_q;

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			since_rst_q <= '0;
			dwell_q     <= '0;
		end
		else
		begin
			if (!(&since_rst_q))
			begin
				since_rst_q <= since_rst_q + CNT_W'(1);
			end
			dwell_q <= (s_d.st != s_q.st) ? '0 : dwell_q + CNT_W'(1);
		end
	end

	// A completing fault recovery overrides the command
	sequence s_drop_cmd;
		cmd_down && (s_q.st == PSC_ST_HIGH) && s_q.fault_oe;
	endsequence

	property p_laser_off;
		@(posedge clk_i) disable iff (sys_rst_i)
		laser_off_req_i |=> !laser_en_o;
	endproperty
	a_laser_off: assert property (p_laser_off)
		else $error("laser stays on under off request");

	property p_laser_on;
		@(posedge clk_i) disable iff (sys_rst_i)
		(!laser_off_req_i && !laser_fault_i && tx_fault_oe_o) |=> laser_en_o;
	endproperty
	a_laser_on: assert property (p_laser_on)
		else $error("laser not restored after release");

	property p_fault_flag;
		@(posedge clk_i) disable iff (sys_rst_i)
		laser_fault_i |=> !tx_fault_oe_o && !laser_en_o;
	endproperty
	a_fault_flag: assert property (p_fault_flag)
		else $error("fault not flagged");

	property p_fault_clear;
		@(posedge clk_i) disable iff (sys_rst_i)
		(!tx_fault_oe_o && !laser_fault_i && hold_done) |=> tx_fault_oe_o;
	endproperty
	a_fault_clear: assert property (p_fault_clear)
		else $error("fault not cleared after hold");

	property p_los;
		@(posedge clk_i) disable iff (sys_rst_i)
		1 |=> (los_oe_o == !$past(light_low_i)) && !los_o;
	endproperty
	a_los: assert property (p_los)
		else $error("signal-lost output wrong");

	property p_absent;
		@(posedge clk_i) disable iff (sys_rst_i)
		1 |-> module_absent_flag_oe_o && !module_absent_flag_o;
	endproperty
	a_absent: assert property (p_absent)
		else $error("module-absent line not grounded");

	property p_serial_ready;
		@(posedge clk_i) disable iff (sys_rst_i)
		(since_rst_q > SERIAL_READY_CYC) |-> serial_if_ready_o;
	endproperty
	a_serial_ready: assert property (p_serial_ready)
		else $error("serial interface late");

	property p_down_bound;
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_q.st == PSC_ST_DOWN) |-> (dwell_q <= POWER_DOWN_CYC + CNT_W'(2));
	endproperty
	a_down_bound: assert property (p_down_bound)
		else $error("power down too slow");

	property p_drop_cmd;
		@(posedge clk_i) disable iff (sys_rst_i)
		s_drop_cmd |=> high_power_o && (s_q.st == PSC_ST_DOWN);
	endproperty
	a_drop_cmd: assert property (p_drop_cmd)
		else $error("down command not taken");

	property p_up_bound;
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_q.st == PSC_ST_UP && !s_q.cooled) |->
			(dwell_q <= HIGH_ENTRY_CYC + CNT_W'(2));
	endproperty
	a_up_bound: assert property (p_up_bound)
		else $error("high power entry too slow");

endmodule : psc_top

//--- tb/psc_host_model.sv
module psc_host_model (
	// Open-drain drivers of the module
	input  wire logic fault_oe_i,
	input  wire logic fault_drv_i,
	input  wire logic los_oe_i,
	input  wire logic los_drv_i,
	input  wire logic abs_oe_i,
	input  wire logic abs_drv_i,
	// Wire levels seen by the host
	output logic      fault_line_o,
	output logic      los_line_o,
	output logic      present_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic abs_line;

	// ------------------------------------------------------------
	// Host pull-ups: released lines read high
	// ------------------------------------------------------------
	assign fault_line_o = fault_oe_i ? fault_drv_i : 1'b1;
	assign los_line_o   = los_oe_i ? los_drv_i : 1'b1;
	assign abs_line     = abs_oe_i ? abs_drv_i : 1'b1;
	assign present_o    = !abs_line;
endmodule : psc_host_model

//--- tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import psc_pkg::*;

	// Arbitrary identity bytes
	localparam logic [63:0] ID = 64'h0011_2233_4455_6677;
	localparam int          SC = 30;
	localparam int          HC = 20;
	// Level selectors for the bounded wait
	localparam int          LV_READY = 0;
	localparam int          LV_OPER  = 1;
	localparam int          LV_HIGH  = 2;

	logic clk_i, sys_rst_i, off_req, fault_in, light_low, rx_pick, tx_pick;
	logic laser_en, fault_drv, fault_oe, los_drv, los_oe, los_seen;
	logic abs_drv, abs_oe, rx_sel, ready, oper, high_pwr;
	logic fault_line, los_line, present, cooled;
	psc_pwr_cmd_t pwr_cmd;
	psc_mem_req_t mem_req;
	psc_diag_t    diag;
	psc_mem_rsp_t mem_rsp;
	int n_errors, n_checks, cyc;

	psc_top #(
		.SERIAL_READY_CYC(34'd40),
		.START_CYC       (34'(SC)),
		.START_COOLED_CYC(34'd60),
		.HIGH_ENTRY_CYC  (34'(HC)),
		.POWER_DOWN_CYC  (34'(HC)),
		.ID_BYTES        (ID)
	) dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.laser_off_req_i(off_req), .laser_fault_i(fault_in),
		.cooled_i(cooled), .laser_en_o(laser_en),
		.tx_fault_o(fault_drv), .tx_fault_oe_o(fault_oe),
		.light_low_i(light_low), .los_line_i(los_line),
		.los_o(los_drv), .los_oe_o(los_oe), .los_line_seen_o(los_seen),
		.module_absent_flag_o(abs_drv),
		.module_absent_flag_oe_o(abs_oe),
		.receive_rate_pick_i(rx_pick), .transmit_rate_pick_i(tx_pick),
		.rx_rate_sel_o(rx_sel), .pwr_cmd_i(pwr_cmd),
		.serial_if_ready_o(ready), .operational_o(oper),
		.high_power_o(high_pwr), .mem_req_i(mem_req), .diag_i(diag),
		.mem_rsp_o(mem_rsp)
	);

	psc_host_model host (
		.fault_oe_i(fault_oe), .fault_drv_i(fault_drv),
		.los_oe_i(los_oe), .los_drv_i(los_drv),
		.abs_oe_i(abs_oe), .abs_drv_i(abs_drv),
		.fault_line_o(fault_line), .los_line_o(los_line),
		.present_o(present)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// Checking and access tasks
	// ------------------------------------------------------------
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask : chk

	task step(input int n);
		repeat (n) @(negedge clk_i);
	endtask : step

	function automatic logic lv_of(input int sel);
		case (sel)
			LV_READY: return ready;
			LV_OPER:  return oper;
			default:  return high_pwr;
		endcase
	endfunction : lv_of

	// Bounded wait for a level, then compare
	task automatic wait_lv(input int sel, input logic lv, input int max,
			input string nm);
		int n;
		n = 0;
		while (lv_of(sel) !== lv && n < max)
		begin
			step(1);
			n++;
		end
		chk(nm, {7'h0, lv}, {7'h0, lv_of(sel)});
	endtask : wait_lv

	// Idle edge after each read keeps the strobe from being rewritten
	task rd(input logic [3:0] a, input logic ok, input logic [7:0] exp);
		mem_req = '{rd: 1'b1, addr: a};
		step(1);
		mem_req = '{rd: 1'b0, addr: a};
		chk("mem ack", 8'h01, {7'h0, mem_rsp.ack});
		chk("mem ok", {7'h0, ok}, {7'h0, mem_rsp.ok});
		chk("mem data", exp, mem_rsp.data);
		step(1);
	endtask : rd

	task cmd(input logic hi);
		pwr_cmd = '{stop: 1'b1, high: hi};
		step(1);
		pwr_cmd = '{stop: 1'b0, high: hi};
	endtask : cmd

	// Hang guard
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			n_errors++;
			report_and_stop();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		n_errors = 0;
		n_checks = 0;
		cyc = 0;
		sys_rst_i = 1'b1;
		off_req = 1'b0;
		fault_in = 1'b0;
		light_low = 1'b0;
		rx_pick = 1'b0;
		tx_pick = 1'b0;
		cooled = 1'b0;
		pwr_cmd = '0;
		mem_req = '0;
		diag = '{temp: 8'ha1, vcc: 8'hb2, bias: 8'hc3, tx_pwr: 8'hd4,
			rx_pwr: 8'he5};
		step(20);
		chk("laser at reset", 8'h00, {7'h0, laser_en});
		chk("present", 8'h01, {7'h0, present});
		chk("fault line", 8'h00, {7'h0, fault_line});
		sys_rst_i = 1'b0;
		step(1);
		rd(4'h8, 1'b0, 8'h00);
		wait_lv(LV_READY, 1'b1, 41, "serial ready");
		wait_lv(LV_OPER, 1'b1, 3, "operational");
		for (int a = 0; a < 8; a++)
			rd(4'(a), 1'b1, ID[8*a+:8]);
		rd(4'h8, 1'b1, 8'ha1);
		rd(4'h9, 1'b1, 8'hb2);
		rd(4'ha, 1'b1, 8'hc3);
		rd(4'hb, 1'b1, 8'hd4);
		rd(4'hc, 1'b1, 8'he5);
		rd(4'hd, 1'b1, 8'h0c);
		rd(4'hf, 1'b1, 8'h00);
		// Transmitter gating and unused rate pick
		chk("laser on", 8'h01, {7'h0, laser_en});
		tx_pick = 1'b1;
		rx_pick = 1'b1;
		step(2);
		chk("tx pick", 8'h01, {7'h0, laser_en});
		chk("rx rate", 8'h01, {7'h0, rx_sel});
		off_req = 1'b1;
		step(1);
		chk("laser off", 8'h00, {7'h0, laser_en});
		off_req = 1'b0;
		step(1);
		chk("laser back", 8'h01, {7'h0, laser_en});
		// Loss of light on the open-drain line
		light_low = 1'b1;
		step(1);
		chk("los line", 8'h01, {7'h0, los_line});
		step(1);
		chk("los seen", 8'h01, {7'h0, los_seen});
		light_low = 1'b0;
		step(1);
		chk("los line", 8'h00, {7'h0, los_line});
		// Power level up and back down
		cmd(1'b1);
		chk("high power", 8'h01, {7'h0, high_pwr});
		chk("oper in up", 8'h00, {7'h0, oper});
		wait_lv(LV_OPER, 1'b1, HC + 2, "high oper");
		cmd(1'b0);
		wait_lv(LV_HIGH, 1'b0, HC + 2, "power down");
		// Latched fault and its clearing hold
		fault_in = 1'b1;
		step(1);
		fault_in = 1'b0;
		chk("fault line", 8'h01, {7'h0, fault_line});
		chk("laser fault", 8'h00, {7'h0, laser_en});
		chk("fault oper", 8'h00, {7'h0, oper});
		off_req = 1'b1;
		step(100);
		off_req = 1'b0;
		step(2);
		chk("short hold", 8'h01, {7'h0, fault_line});
		off_req = 1'b1;
		step(1260);
		chk("fault clear", 8'h00, {7'h0, fault_line});
		off_req = 1'b0;
		wait_lv(LV_OPER, 1'b1, SC + 3, "recovery");
		chk("laser again", 8'h01, {7'h0, laser_en});
		// Second reset with the cooled strap: longer start-up
		sys_rst_i = 1'b1;
		cooled = 1'b1;
		step(2);
		chk("rst laser", 8'h00, {7'h0, laser_en});
		chk("rst ready", 8'h00, {7'h0, ready});
		sys_rst_i = 1'b0;
		step(40);
		chk("cooled early", 8'h00, {7'h0, oper});
		wait_lv(LV_OPER, 1'b1, 23, "cooled start");
		report_and_stop();
	end
endmodule : testbench
